// ### pmc_pkg.sv
// Constants for the power-management capability register block.
package pmc_pkg;
    localparam int PMC_ADDR_W = 8;
    localparam int PMC_DATA_W = 32;
    localparam int PMC_BE_W = 4;
    localparam int PMC_HALF_W = 16;
    // Configuration offsets of the three registers.
    localparam logic [7:0] PMC_OFS_CAP_HDR = 8'h44;
    localparam logic [7:0] PMC_OFS_CAPS = 8'h46;
    localparam logic [7:0] PMC_OFS_CSR = 8'h48;
    // Dword index of the header and control/status offsets, taken from address bits 7 to 2.
    localparam logic [5:0] PMC_DW_CAP = PMC_OFS_CAP_HDR[7:2];
    localparam logic [5:0] PMC_DW_CSR = PMC_OFS_CSR[7:2];
    // Capability header fields.
    localparam logic [7:0] PMC_CAP_CODE = 8'h01;
    localparam logic [7:0] PMC_NEXT_PTR = 8'h00;
    localparam logic [15:0] PMC_CAP_HDR_RESET = 16'h0001;
    // Capabilities word fields.
    localparam logic [3:0] PMC_WAKE_STATE_MASK = 4'hf;
    localparam logic PMC_STATE_TWO_ALLOWED = 1'b1;
    localparam logic PMC_STATE_ONE_ALLOWED = 1'b1;
    localparam logic [2:0] PMC_AUX_SELF = 3'h0;
    localparam logic [2:0] PMC_AUX_55MA = 3'h1;
    localparam logic PMC_DEV_INIT = 1'b0;
    localparam logic PMC_CAPS_RSVD = 1'b0;
    localparam logic PMC_WAKE_NEEDS_CLOCK = 1'b0;
    localparam logic [2:0] PMC_POWER_SPEC_VERSION = 3'h2;
    localparam logic [15:0] PMC_CAPS_RESET = 16'h7e02;
    // Control/status word fields.
    localparam int PMC_CSR_STAT_BIT = 15;
    localparam int PMC_CSR_EN_BIT = 8;
    localparam int PMC_CSR_PS_LSB = 0;
    localparam int PMC_CSR_PS_MSB = 1;
    localparam logic [1:0] PMC_DATA_SCALE = 2'h0;
    localparam logic [3:0] PMC_DATA_SELECT = 4'h0;
    localparam logic [5:0] PMC_CSR_RSVD = 6'h00;
    localparam logic [15:0] PMC_CSR_RESET = 16'h0000;
    // Byte lanes that carry the writable control/status bits.
    localparam int PMC_BE_CSR_LO = 0;
    localparam int PMC_BE_CSR_HI = 1;
    // Power state encodings.
    typedef enum logic [1:0] {
        PMC_D0 = 2'h0,
        PMC_D1 = 2'h1,
        PMC_D2 = 2'h2,
        PMC_D3HOT = 2'h3
    } pmc_state_e;
endpackage : pmc_pkg

// ### pmc_regs.sv
// Power-management capability registers behind the configuration access port.
// How it works
// [R01] Capability header low byte always reads 01h.
// [R02] Capability header high byte, the next pointer, always reads zero.
// [R03] Wake-support field, bits 14 to 11, reads all ones.
// [R04] State_two_allowed bit reads one; D2 state writes are accepted.
// [R05] State_one_allowed bit reads one; D1 state writes are accepted.
// [R06] Auxiliary current reads 000b without cold wake support, 001b with it.
// [R07] Device-specific-initialization bit reads zero.
// [R08] Capabilities bit 4 reads zero.
// [R09] Wake-clock bit reads zero.
// [R10] Version field reads 010b.
// [R11] Control/status word keeps its contents across the D3hot-to-D0 function reset.
// [R12] Wake-event status resets to zero and is set by events, cleared by software.
// [R13] Data-scale and data-select fields read zero.
// [R14] Wake-enable bit is host writable; wake is signalled only while set.
// [R15] Control/status bits 7 to 2 read zero.
// [R16] Host writes power state; reads report current state, D0 to D3hot.
// [R17] Status, enable and power state are reset only by the global reset.
// [R18] Cold wake-support bit follows the general control bit.
// [R19] Wake output is active while both status and enable are set.
// [R20] Writing one clears wake status; writing zero leaves it.
`timescale 1ns/10ps
module pmc_regs (
    // Clock and global reset.
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Configuration access port.
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [pmc_pkg::PMC_ADDR_W-1:0] cfg_addr_i,
    input wire logic [pmc_pkg::PMC_BE_W-1:0] cfg_be_i,
    input wire logic [pmc_pkg::PMC_DATA_W-1:0] cfg_wdata_i,
    output logic [pmc_pkg::PMC_DATA_W-1:0] cfg_rdata_o,
    output logic cfg_ack_o,
    // Function side.
    input wire logic cold_wake_support_ctl_i,
    input wire logic wake_event_i,
    output logic wake_o,
    output logic [1:0] power_state_o
);
    import pmc_pkg::*;

    logic wake_event_status;
    logic wake_event_enable;
    pmc_state_e power_state_field;
    logic next_wake_event_status;
    logic next_wake_event_enable;
    pmc_state_e next_power_state_field;
    logic next_wake;
    logic next_ack;
    logic [PMC_DATA_W-1:0] next_rdata;
    logic [PMC_HALF_W-1:0] cap_hdr_word;
    logic [PMC_HALF_W-1:0] caps_word;
    logic [PMC_HALF_W-1:0] csr_word;
    logic [2:0] aux_current;
    logic wake_from_cold_support;
    logic hit_cap;
    logic hit_csr;

    // Read values of the three registers.
    always_comb begin
        wake_from_cold_support = cold_wake_support_ctl_i; // [R18]
        aux_current = wake_from_cold_support ? PMC_AUX_55MA : PMC_AUX_SELF; // [R06]
        cap_hdr_word = {PMC_NEXT_PTR, PMC_CAP_CODE}; // [R01] [R02]
        caps_word = {wake_from_cold_support,
                     PMC_WAKE_STATE_MASK, // [R03]
                     PMC_STATE_TWO_ALLOWED, // [R04]
                     PMC_STATE_ONE_ALLOWED, // [R05]
                     aux_current,
                     PMC_DEV_INIT, // [R07]
                     PMC_CAPS_RSVD, // [R08]
                     PMC_WAKE_NEEDS_CLOCK, // [R09]
                     PMC_POWER_SPEC_VERSION}; // [R10]
        csr_word = {wake_event_status,
                    PMC_DATA_SCALE, PMC_DATA_SELECT, // [R13]
                    wake_event_enable,
                    PMC_CSR_RSVD, // [R15]
                    power_state_field}; // [R16]
        hit_cap = (cfg_addr_i[7:2] == PMC_DW_CAP);
        hit_csr = (cfg_addr_i[7:2] == PMC_DW_CSR);
    end

    // Next values of control/status state and of the access answer.
    always_comb begin
        next_wake_event_status = wake_event_status;
        next_wake_event_enable = wake_event_enable;
        next_power_state_field = power_state_field;
        next_ack = cfg_rd_i | cfg_wr_i;
        next_rdata = '0;
        if (cfg_wr_i && hit_csr) begin
            if (cfg_be_i[PMC_BE_CSR_LO]) begin
                // Every encoding, D1 and D2 included, is accepted.
                next_power_state_field =
                    pmc_state_e'(cfg_wdata_i[PMC_CSR_PS_MSB:PMC_CSR_PS_LSB]); // [R16] [R04] [R05]
            end
            if (cfg_be_i[PMC_BE_CSR_HI]) begin
                next_wake_event_enable = cfg_wdata_i[PMC_CSR_EN_BIT]; // [R14]
                if (cfg_wdata_i[PMC_CSR_STAT_BIT]) begin
                    next_wake_event_status = 1'b0; // [R20]
                end
            end
        end
        // A wake event in the same cycle as a clear keeps the flag set.
        if (wake_event_i) begin
            next_wake_event_status = 1'b1; // [R12]
        end
        next_wake = next_wake_event_status & next_wake_event_enable; // [R19] [R14]
        if (cfg_rd_i) begin
            if (hit_cap) begin
                next_rdata = {caps_word, cap_hdr_word};
            end else if (hit_csr) begin
                // The bridge extension and data bytes above read as zero.
                next_rdata = {{PMC_HALF_W{1'b0}}, csr_word};
            end else begin
                next_rdata = '0;
            end
        end
    end

    // Only the global reset resets this state; no function reset reaches it.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wake_event_status <= PMC_CSR_RESET[PMC_CSR_STAT_BIT]; // [R12] [R17] [R11]
            wake_event_enable <= PMC_CSR_RESET[PMC_CSR_EN_BIT]; // [R17]
            power_state_field <= PMC_D0; // [R17]
            wake_o <= 1'b0;
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= '0;
        end else begin
            wake_event_status <= next_wake_event_status;
            wake_event_enable <= next_wake_event_enable;
            power_state_field <= next_power_state_field;
            wake_o <= next_wake;
            cfg_ack_o <= next_ack;
            cfg_rdata_o <= next_rdata;
        end
    end

    assign power_state_o = power_state_field;

    default clocking pmc_cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    a_hdr_code_read: assert property ( // [R01]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[7:0] == 8'h01)
        else $error("Capability code did not read 01h.");

    a_hdr_next_zero: assert property ( // [R02]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[15:8] == 8'h00)
        else $error("Next pointer did not read zero.");

    a_caps_fixed_bits: assert property ( // [R03]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[30:25] == 6'h3f && cfg_rdata_o[21:16] == 6'h02)
        else $error("Fixed capability bits read wrong.");

    a_caps_aux_current: assert property ( // [R06]
        cfg_rd_i && hit_cap |=>
            cfg_rdata_o[24:22] == ($past(cold_wake_support_ctl_i) ? 3'h1 : 3'h0)
            && cfg_rdata_o[31] == $past(cold_wake_support_ctl_i))
        else $error("Auxiliary current or cold wake bit wrong.");

    a_csr_zero_fields: assert property ( // [R13]
        cfg_rd_i && hit_csr |=>
            cfg_rdata_o[14:9] == 6'h00 && cfg_rdata_o[7:2] == 6'h00
            && cfg_rdata_o[31:16] == 16'h0000)
        else $error("Control/status zero fields read nonzero.");

    a_state_write_read: assert property ( // [R16]
        cfg_wr_i && hit_csr && cfg_be_i[0] |=> power_state_o == $past(cfg_wdata_i[1:0]))
        else $error("Power state did not take the written value.");

    a_state_read_back: assert property ( // [R16]
        cfg_rd_i && hit_csr && !cfg_wr_i |=> cfg_rdata_o[1:0] == power_state_o)
        else $error("Power state did not read back as held.");

    a_stat_event_set: assert property ( // [R12]
        wake_event_i |=> wake_event_status)
        else $error("Wake event did not set status.");

    a_stat_read_back: assert property ( // [R12]
        wake_event_status && cfg_rd_i && hit_csr |=> cfg_rdata_o[15])
        else $error("Set wake status did not read back.");

    a_stat_clear_one: assert property ( // [R20]
        cfg_wr_i && hit_csr && cfg_be_i[1] && cfg_wdata_i[15] && !wake_event_i
        |=> !wake_event_status && !wake_o)
        else $error("Writing one did not clear wake status.");

    a_stat_keep_zero: assert property ( // [R20]
        wake_event_status && cfg_wr_i && cfg_be_i[1] && !cfg_wdata_i[15] |=> wake_event_status)
        else $error("Writing zero changed wake status.");

    a_wake_gated: assert property ( // [R19]
        wake_o == (wake_event_status && wake_event_enable))
        else $error("Wake output does not match status and enable.");

    a_wake_needs_en: assert property ( // [R14]
        !wake_event_enable |-> !wake_o)
        else $error("Wake signalled with enable clear.");

    a_access_ack: assert property (
        (cfg_rd_i || cfg_wr_i) |=> cfg_ack_o)
        else $error("Access was not answered.");

    a_ack_only_after: assert property (
        !(cfg_rd_i || cfg_wr_i) |=> !cfg_ack_o)
        else $error("Answer given without an access.");

    a_global_reset: assert property ( // [R17]
        @(posedge core_clk_i) disable iff (1'b0)
        srst_i |=> !wake_event_status && !wake_event_enable && power_state_o == 2'h0 && !wake_o)
        else $error("Global reset did not clear control/status.");

    a_hdr_whole_word: assert property ( // [R01]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[15:0] == PMC_CAP_HDR_RESET)
        else $error("Capability header word read wrong.");

    a_caps_reset_word: assert property ( // [R03]
        cfg_rd_i && hit_cap && !cold_wake_support_ctl_i |=> cfg_rdata_o[31:16] == PMC_CAPS_RESET)
        else $error("Capabilities word without cold wake read wrong.");

    a_caps_wake_mask: assert property ( // [R03]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[30:27] == 4'hf)
        else $error("Wake-support field did not read all ones.");

    a_caps_state_two: assert property ( // [R04]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[26])
        else $error("State_two_allowed bit did not read one.");

    a_caps_state_one: assert property ( // [R05]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[25])
        else $error("State_one_allowed bit did not read one.");

    a_caps_dev_init: assert property ( // [R07]
        cfg_rd_i && hit_cap |=> !cfg_rdata_o[21])
        else $error("Device-specific-initialization bit read one.");

    a_caps_rsvd_zero: assert property ( // [R08]
        cfg_rd_i && hit_cap |=> !cfg_rdata_o[20])
        else $error("Capabilities bit 4 read one.");

    a_caps_clock_free: assert property ( // [R09]
        cfg_rd_i && hit_cap |=> !cfg_rdata_o[19])
        else $error("Wake-clock bit read one.");

    a_caps_version: assert property ( // [R10]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[18:16] == 3'h2)
        else $error("Version field did not read 010b.");

    a_cold_follows_ctl: assert property ( // [R18]
        cfg_rd_i && hit_cap |=> cfg_rdata_o[31] == $past(cold_wake_support_ctl_i))
        else $error("Cold wake-support bit did not follow its control.");

    a_state_two_taken: assert property ( // [R04]
        cfg_wr_i && hit_csr && cfg_be_i[0] && cfg_wdata_i[1:0] == 2'h2
        |=> power_state_o == 2'h2)
        else $error("D2 state write was not accepted.");

    a_state_one_taken: assert property ( // [R05]
        cfg_wr_i && hit_csr && cfg_be_i[0] && cfg_wdata_i[1:0] == 2'h1
        |=> power_state_o == 2'h1)
        else $error("D1 state write was not accepted.");

    a_state_hold: assert property ( // [R17]
        !(cfg_wr_i && hit_csr && cfg_be_i[0]) |=> $stable(power_state_o))
        else $error("Power state changed without a write.");

    a_enable_hold: assert property ( // [R17]
        !(cfg_wr_i && hit_csr && cfg_be_i[1]) |=> $stable(wake_event_enable))
        else $error("Wake enable changed without a write.");

    a_status_clear_only: assert property ( // [R17]
        wake_event_status && !(cfg_wr_i && hit_csr && cfg_be_i[1] && cfg_wdata_i[15])
        |=> wake_event_status)
        else $error("Wake status cleared without a clearing write.");

    a_status_no_self: assert property ( // [R12]
        !wake_event_status && !wake_event_i |=> !wake_event_status)
        else $error("Wake status set without an event.");

    a_set_beats_clear: assert property ( // [R12]
        wake_event_i && cfg_wr_i && hit_csr && cfg_be_i[1] && cfg_wdata_i[15]
        |=> wake_event_status)
        else $error("Clearing write overrode a wake event.");

    a_enable_write: assert property ( // [R14]
        cfg_wr_i && hit_csr && cfg_be_i[1] |=> wake_event_enable == $past(cfg_wdata_i[8]))
        else $error("Wake enable did not take the written value.");

    a_enable_read: assert property ( // [R14]
        cfg_rd_i && hit_csr |=> cfg_rdata_o[8] == $past(wake_event_enable))
        else $error("Wake enable did not read back.");

    a_csr_rsvd_zero: assert property ( // [R15]
        cfg_rd_i && hit_csr |=> cfg_rdata_o[7:2] == 6'h00)
        else $error("Control/status bits 7 to 2 read nonzero.");

    a_csr_data_zero: assert property ( // [R13]
        cfg_rd_i && hit_csr |=> cfg_rdata_o[14:9] == 6'h00)
        else $error("Data-scale or data-select read nonzero.");

    a_wake_follows_event: assert property ( // [R19]
        wake_event_i && wake_event_enable && !(cfg_wr_i && hit_csr && cfg_be_i[1]) |=> wake_o)
        else $error("Enabled wake event did not raise the wake output.");

    a_rdata_idle_zero: assert property (
        !cfg_rd_i |=> cfg_rdata_o == '0)
        else $error("Read data not zero outside a read answer.");

    a_reset_answer_clear: assert property (
        @(posedge core_clk_i) disable iff (1'b0)
        srst_i |=> !cfg_ack_o && cfg_rdata_o == '0)
        else $error("Global reset did not clear the access answer.");

endmodule : pmc_regs

// ### pmc_host_model.sv
// Host model issuing configuration reads and writes to the register block.
`timescale 1ns/10ps
module pmc_host_model (
    // Clock.
    input wire logic core_clk_i,
    // Configuration access port.
    output logic cfg_rd_o,
    output logic cfg_wr_o,
    output logic [pmc_pkg::PMC_ADDR_W-1:0] cfg_addr_o,
    output logic [pmc_pkg::PMC_BE_W-1:0] cfg_be_o,
    output logic [pmc_pkg::PMC_DATA_W-1:0] cfg_wdata_o,
    input wire logic [pmc_pkg::PMC_DATA_W-1:0] cfg_rdata_i,
    input wire logic cfg_ack_i
);
    import pmc_pkg::*;
    initial begin
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_addr_o = 8'h00;
        cfg_be_o = 4'h0;
        cfg_wdata_o = 32'h0;
    end
    // One access: a one-cycle request, then the answer taken one cycle later.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
            input logic [31:0] data, output logic [31:0] rdata, output logic ack);
        @(posedge core_clk_i);
        #2;
        cfg_rd_o = !wr;
        cfg_wr_o = wr;
        cfg_addr_o = addr;
        cfg_be_o = be;
        cfg_wdata_o = data;
        @(posedge core_clk_i);
        #2;
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        // Released address, byte-enable and data lines show the inverse of the last value; read and write drop to zero.
        cfg_addr_o = ~addr;
        cfg_be_o = ~be;
        cfg_wdata_o = ~data;
        rdata = cfg_rdata_i;
        ack = cfg_ack_i;
    endtask : access
endmodule : pmc_host_model

// ### tb_pmc_regs.sv
// Self-checking testbench for the power-management capability registers.
`timescale 1ns/10ps
module tb_pmc_regs;
    import pmc_pkg::*;
    logic core_clk_i, srst_i, cold_i, ev_i, wake_o, rd, wr, ack;
    logic [1:0] ps_o;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata;
    int mismatches = 0;
    int n_tests = 0;
    pmc_regs i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .cfg_rd_i(rd), .cfg_wr_i(wr),
        .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
        .cfg_ack_o(ack), .cold_wake_support_ctl_i(cold_i), .wake_event_i(ev_i),
        .wake_o(wake_o), .power_state_o(ps_o));
    pmc_host_model i_host (.core_clk_i(core_clk_i), .cfg_rd_o(rd), .cfg_wr_o(wr),
        .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata), .cfg_rdata_i(rdata),
        .cfg_ack_i(ack));
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One access; a read is compared with the expected word.
    task automatic acc(input int w, input logic [7:0] a, input logic [3:0] b,
            input logic [31:0] d, input logic [31:0] exp);
        logic [31:0] r;
        logic k;
        i_host.access(w != 0, a, b, d, r, k);
        check("ack", 32'h1, {31'h0, k});
        if (w == 0) check("rdata", exp, r);
    endtask : acc
    task automatic pulse_event();
        @(posedge core_clk_i);
        #2;
        ev_i = 1'b1;
        @(posedge core_clk_i);
        #2;
        ev_i = 1'b0;
        @(posedge core_clk_i);
        #2;
    endtask : pulse_event
    task automatic t_fixed_fields();
        acc(0, 8'h44, 4'hf, 32'h0, 32'h7e020001);
        acc(0, 8'h48, 4'hf, 32'h0, 32'h00000000);
        cold_i = 1'b1;
        acc(0, 8'h46, 4'hf, 32'h0, 32'hfe420001);
        cold_i = 1'b0;
        acc(1, 8'h44, 4'hf, 32'hffffffff, 32'h0);
        acc(0, 8'h44, 4'hf, 32'h0, 32'h7e020001);
        acc(1, 8'h4c, 4'hf, 32'hffffffff, 32'h0);
        acc(0, 8'h4c, 4'hf, 32'h0, 32'h0);
    endtask : t_fixed_fields
    task automatic t_power_states();
        for (int s = 0; s < 4; s++) begin
            acc(1, 8'h48, 4'h1, 32'hfffffffc | s, 32'h0);
            check("power_state_o", s, {30'h0, ps_o});
            acc(0, 8'h48, 4'hf, 32'h0, s);
        end
    endtask : t_power_states
    task automatic t_wake();
        pulse_event();
        check("wake_o off", 32'h0, {31'h0, wake_o});
        acc(0, 8'h48, 4'hf, 32'h0, 32'h00008003);
        acc(1, 8'h48, 4'h2, 32'h00007f00, 32'h0);
        check("wake_o on", 32'h1, {31'h0, wake_o});
        acc(0, 8'h48, 4'hf, 32'h0, 32'h00008103);
        acc(1, 8'h48, 4'h1, 32'h00000000, 32'h0);
        acc(0, 8'h48, 4'hf, 32'h0, 32'h00008100);
        acc(1, 8'h48, 4'h2, 32'h00008100, 32'h0);
        acc(0, 8'h48, 4'hf, 32'h0, 32'h00000100);
        check("wake_o cleared", 32'h0, {31'h0, wake_o});
    endtask : t_wake
    // A wake event in the same cycle as a clearing write leaves the status set.
    task automatic t_set_beats_clear();
        fork
            acc(1, 8'h48, 4'h2, 32'h00008100, 32'h0);
            pulse_event();
        join
        check("wake_o set wins", 32'h1, {31'h0, wake_o});
        acc(0, 8'h48, 4'hf, 32'h0, 32'h00008100);
        acc(1, 8'h48, 4'h2, 32'h00008100, 32'h0);
        acc(0, 8'h48, 4'hf, 32'h0, 32'h00000100);
    endtask : t_set_beats_clear
    task automatic t_global_reset();
        acc(1, 8'h48, 4'h1, 32'h2, 32'h0);
        pulse_event();
        @(posedge core_clk_i);
        #2;
        srst_i = 1'b1;
        @(posedge core_clk_i);
        #2;
        srst_i = 1'b0;
        check("reset outputs", 32'h0, {29'h0, wake_o, ps_o});
        acc(0, 8'h48, 4'hf, 32'h0, 32'h0);
    endtask : t_global_reset
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        srst_i = 1'b1;
        cold_i = 1'b0;
        ev_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        #2;
        srst_i = 1'b0;
        t_fixed_fields();
        t_power_states();
        t_wake();
        t_set_beats_clear();
        t_global_reset();
        complete_run();
    end
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
endmodule : tb_pmc_regs
